// File: verilog/sdsr_pkg.sv
// package: constants and carrier types for the serial and dma subbank register block
package sdsr_pkg;
	// bus widths
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	// number of serial port instances and bank depths
	localparam int SER_NUM = 3;
	localparam int SER_DEPTH = 28;
	localparam int DMA_DEPTH = 63;
	// serial pointer locations, index = port number
	localparam logic [ADDR_W-1:0] SER_PTR_ADDR [SER_NUM] = '{16'h0038, 16'h0048, 16'h0034};
	// serial data port locations, index = port number
	localparam logic [ADDR_W-1:0] SER_DATA_ADDR [SER_NUM] = '{16'h0039, 16'h0049, 16'h0035};
	// dma direct and subbank locations
	localparam logic [ADDR_W-1:0] DMA_PRIO_ADDR = 16'h0054;
	localparam logic [ADDR_W-1:0] DMA_PTR_ADDR = 16'h0055;
	localparam logic [ADDR_W-1:0] DMA_AUTOINC_ADDR = 16'h0056;
	localparam logic [ADDR_W-1:0] DMA_PLAIN_ADDR = 16'h0057;
	// serial bank subaddresses
	localparam logic [DATA_W-1:0] SER_SUB_PORT_CTL = 16'h0000;
	localparam logic [DATA_W-1:0] SER_SUB_RX_CTL = 16'h0002;
	localparam logic [DATA_W-1:0] SER_SUB_TX_CTL = 16'h0004;
	localparam logic [DATA_W-1:0] SER_SUB_RATE_GEN = 16'h0006;
	localparam logic [DATA_W-1:0] SER_SUB_MULTICH = 16'h0008;
	localparam logic [DATA_W-1:0] SER_SUB_CH_EN_AB = 16'h000a;
	localparam logic [DATA_W-1:0] SER_SUB_PIN_CTL = 16'h000e;
	localparam logic [DATA_W-1:0] SER_SUB_HOLE = 16'h000f;
	localparam logic [DATA_W-1:0] SER_SUB_CH_EN_CH = 16'h0010;
	localparam logic [DATA_W-1:0] SER_SUB_LAST = 16'h001b;
	// dma bank subaddresses
	localparam logic [DATA_W-1:0] DMA_SUB_CH_STRIDE = 16'h0005;
	localparam logic [DATA_W-1:0] DMA_SUB_CH_LAST = 16'h001d;
	localparam logic [DATA_W-1:0] DMA_SUB_SRC_PAGE = 16'h001e;
	localparam logic [DATA_W-1:0] DMA_SUB_DST_PAGE = 16'h001f;
	localparam logic [DATA_W-1:0] DMA_SUB_HOLE_LO = 16'h0028;
	localparam logic [DATA_W-1:0] DMA_SUB_HOLE_HI = 16'h0029;
	localparam logic [DATA_W-1:0] DMA_SUB_LAST = 16'h003e;
	// reset values, read-back zero and pointer step
	localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] PTR_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;
	localparam logic [DATA_W-1:0] PTR_STEP = 16'h0001;
	// one register bus request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} sdsr_req_t;
	// registered answer
	typedef struct packed {
		logic ack;
		logic hit;
		logic [DATA_W-1:0] rdata;
	} sdsr_rsp_t;
endpackage : sdsr_pkg

// File: verilog/sdsr_top.sv
// module: indirect register banks for three serial ports and the dma controller
// Behaviour
// - serial control registers reached only via pointer
// - serial data port acts on selected register
// - subaddresses 00h-05h: port, receive, transmit controls
// - 06h-07h rate generator, 08h-09h multichannel
// - 0Ah-0Dh channel enables A/B, 0Eh pin control
// - 10h-1Bh extra channel enables, partitions C-H
// - dma priority register directly mapped, not subbanked
// - dma pointer selects; either dma port accesses
// - autoincrement port bumps pointer after each access
// - channel n uses subaddresses 5n to 5n+4
// - subaddress 1Eh is shared source program page
// - 1Fh-27h and 2Ah-3Eh page, index, reload, channel enable registers
`timescale 1ns/1ps
`default_nettype none
module sdsr_top
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// processor register bus
	input wire sdsr_pkg::sdsr_req_t mmr_req,
	output sdsr_pkg::sdsr_rsp_t mmr_rsp,
	// register contents toward the serial ports
	output logic [sdsr_pkg::SER_NUM-1:0][sdsr_pkg::SER_DEPTH-1:0][sdsr_pkg::DATA_W-1:0] serial_bank,
	// register contents toward the dma controller
	output logic [sdsr_pkg::DMA_DEPTH-1:0][sdsr_pkg::DATA_W-1:0] dma_bank,
	output logic [sdsr_pkg::DATA_W-1:0] dma_priority_enable_ctl
);

	// true when a serial subaddress names a real register
	function automatic logic serial_sub_ok(input logic [sdsr_pkg::DATA_W-1:0] sub);
		serial_sub_ok = (sub <= sdsr_pkg::SER_SUB_LAST) && (sub != sdsr_pkg::SER_SUB_HOLE);
	endfunction : serial_sub_ok

	// true when a dma subaddress names a real register
	function automatic logic dma_sub_ok(input logic [sdsr_pkg::DATA_W-1:0] sub);
		dma_sub_ok = (sub <= sdsr_pkg::DMA_SUB_LAST) && (sub != sdsr_pkg::DMA_SUB_HOLE_LO)
			&& (sub != sdsr_pkg::DMA_SUB_HOLE_HI);
	endfunction : dma_sub_ok

	// serial subbank pointers, one per port
	logic [sdsr_pkg::SER_NUM-1:0][sdsr_pkg::DATA_W-1:0] serial_sub_pointer;
	// dma subbank pointer
	logic [sdsr_pkg::DATA_W-1:0] dma_sub_pointer;
	// dma data port strobes
	logic dma_port_hit;
	logic dma_autoinc_hit;
	// combinational read result
	logic [sdsr_pkg::DATA_W-1:0] next_rdata;
	logic next_hit;

	// dma data port decode, shared by read, write and pointer logic
	assign dma_autoinc_hit = (mmr_req.addr == sdsr_pkg::DMA_AUTOINC_ADDR);
	assign dma_port_hit = dma_autoinc_hit || (mmr_req.addr == sdsr_pkg::DMA_PLAIN_ADDR);

	// per serial port: pointer and bank storage
	genvar gi;
	generate
		for (gi = 0; gi < sdsr_pkg::SER_NUM; gi++)
		begin : g_serial
			// pointer changes only by a write to its own location
			always_ff @(posedge mclk)
			begin
				if (rst)
				begin
					serial_sub_pointer[gi] <= sdsr_pkg::PTR_RESET;
				end
				else if (mmr_req.wr && (mmr_req.addr == sdsr_pkg::SER_PTR_ADDR[gi]))
				begin
					serial_sub_pointer[gi] <= mmr_req.wdata;
				end
			end

			// data port write lands in the selected register
			always_ff @(posedge mclk)
			begin
				if (rst)
				begin
					serial_bank[gi] <= '0;
				end
				else if (mmr_req.wr && (mmr_req.addr == sdsr_pkg::SER_DATA_ADDR[gi])
					&& serial_sub_ok(serial_sub_pointer[gi]))
				begin
					// subaddress is the storage index: 00h-0Eh and 10h-1Bh map straight through
					serial_bank[gi][serial_sub_pointer[gi][4:0]] <= mmr_req.wdata;
				end
			end
		end
	endgenerate

	// dma pointer: direct write, or post increment after autoinc port access
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			dma_sub_pointer <= sdsr_pkg::PTR_RESET;
		end
		else if (mmr_req.wr && (mmr_req.addr == sdsr_pkg::DMA_PTR_ADDR))
		begin
			dma_sub_pointer <= mmr_req.wdata;
		end
		else if ((mmr_req.wr || mmr_req.rd) && dma_autoinc_hit)
		begin
			dma_sub_pointer <= dma_sub_pointer + sdsr_pkg::PTR_STEP;
		end
		// plain port access leaves the pointer alone
		else
		begin
			dma_sub_pointer <= dma_sub_pointer;
		end
	end

	// dma subbank storage, written through either data port
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			dma_bank <= '0;
		end
		else if (mmr_req.wr && dma_port_hit && dma_sub_ok(dma_sub_pointer))
		begin
			// channel n at 5n..5n+4, then 1Eh source page, 1Fh-3Eh upper registers except the holes at 28h-29h
			dma_bank[dma_sub_pointer[5:0]] <= mmr_req.wdata;
		end
	end

	// dma priority and enable control, an ordinary direct register
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			dma_priority_enable_ctl <= sdsr_pkg::REG_RESET;
		end
		else if (mmr_req.wr && (mmr_req.addr == sdsr_pkg::DMA_PRIO_ADDR))
		begin
			dma_priority_enable_ctl <= mmr_req.wdata;
		end
	end

	// read decode
	always_comb
	begin
		next_rdata = sdsr_pkg::READ_ZERO;
		next_hit = 1'b0;
		// serial pointers and data ports
		for (int i = 0; i < sdsr_pkg::SER_NUM; i++)
		begin
			if (mmr_req.addr == sdsr_pkg::SER_PTR_ADDR[i])
			begin
				next_rdata = serial_sub_pointer[i];
				next_hit = 1'b1;
			end
			else if (mmr_req.addr == sdsr_pkg::SER_DATA_ADDR[i])
			begin
				next_hit = 1'b1;
				// empty subaddress reads zero
				if (serial_sub_ok(serial_sub_pointer[i]))
				begin
					next_rdata = serial_bank[i][serial_sub_pointer[i][4:0]];
				end
			end
		end
		// dma direct registers
		if (mmr_req.addr == sdsr_pkg::DMA_PRIO_ADDR)
		begin
			next_rdata = dma_priority_enable_ctl;
			next_hit = 1'b1;
		end
		else if (mmr_req.addr == sdsr_pkg::DMA_PTR_ADDR)
		begin
			next_rdata = dma_sub_pointer;
			next_hit = 1'b1;
		end
		// dma data ports read the register selected before any increment
		else if (dma_port_hit)
		begin
			next_hit = 1'b1;
			if (dma_sub_ok(dma_sub_pointer))
			begin
				next_rdata = dma_bank[dma_sub_pointer[5:0]];
			end
		end
	end

	// registered answer: one cycle after a read or write request
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			mmr_rsp <= '0;
		end
		else
		begin
			mmr_rsp.ack <= mmr_req.rd || mmr_req.wr;
			mmr_rsp.hit <= (mmr_req.rd || mmr_req.wr) && next_hit;
			// read data only follows a read; held at zero otherwise
			mmr_rsp.rdata <= mmr_req.rd ? next_rdata : sdsr_pkg::READ_ZERO;
		end
	end

endmodule : sdsr_top
`default_nettype wire

// File: testbench/sdsr_checker.sv
// port assertions for the subbank register block
`timescale 1ns/1ps
`default_nettype none
module sdsr_checker
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// register bus
	input wire sdsr_pkg::sdsr_req_t mmr_req,
	input wire sdsr_pkg::sdsr_rsp_t mmr_rsp,
	// register contents
	input wire logic [2:0][27:0][15:0] serial_bank,
	input wire logic [62:0][15:0] dma_bank,
	input wire logic [15:0] dma_priority_enable_ctl
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// every request answered on the next edge
	a_ack_follows: assert property ((mmr_req.wr || mmr_req.rd) |=> mmr_rsp.ack)
		else $error("ack missing");
	a_ack_idle: assert property (!(mmr_req.wr || mmr_req.rd) |=> !mmr_rsp.ack)
		else $error("ack without request");
	a_rdata_idle: assert property (!mmr_req.rd |=> mmr_rsp.rdata == 16'h0000)
		else $error("rdata not zero");
	// direct register takes written word
	a_prio_write: assert property ((mmr_req.wr && mmr_req.addr == 16'h0054)
		|=> dma_priority_enable_ctl == $past(mmr_req.wdata))
		else $error("priority write lost");
	a_prio_hold: assert property (!(mmr_req.wr && mmr_req.addr == 16'h0054)
		|=> $stable(dma_priority_enable_ctl))
		else $error("priority changed");
	// empty places stay zero
	a_serial_hole: assert property (serial_bank[0][15] == 16'h0000 && serial_bank[1][15] == 16'h0000 && serial_bank[2][15] == 16'h0000)
		else $error("serial hole written");
	a_dma_hole: assert property (dma_bank[40] == 16'h0000 && dma_bank[41] == 16'h0000)
		else $error("dma hole written");
	a_banks_hold: assert property (!mmr_req.wr |=> $stable(serial_bank) && $stable(dma_bank))
		else $error("bank changed without write");
	a_hit_pointer: assert property ((mmr_req.rd && mmr_req.addr == 16'h0055) |=> mmr_rsp.hit)
		else $error("pointer not hit");
	a_hit_unmapped: assert property ((mmr_req.rd && mmr_req.addr == 16'h0036) |=> !mmr_rsp.hit)
		else $error("unmapped hit");
endmodule : sdsr_checker
bind sdsr_top sdsr_checker sdsr_checker_i (.mclk(mclk), .rst(rst), .mmr_req(mmr_req), .mmr_rsp(mmr_rsp),
	.serial_bank(serial_bank), .dma_bank(dma_bank), .dma_priority_enable_ctl(dma_priority_enable_ctl));
`default_nettype wire

// File: testbench/sdsr_top_tb.sv
// self-checking bench for the subbank register block
`timescale 1ns/1ps
`default_nettype none
module sdsr_top_tb;
	logic mclk; // clock
	logic rst; // reset
	sdsr_pkg::sdsr_req_t mmr_req; // request
	sdsr_pkg::sdsr_rsp_t mmr_rsp; // answer
	logic [2:0][27:0][15:0] serial_bank; // serial banks
	logic [62:0][15:0] dma_bank; // dma bank
	logic [15:0] dma_priority_enable_ctl; // direct register
	int miscompares; // mismatches
	int samples_checked; // comparisons
	int cyc; // watchdog
	sdsr_top sdsr_top_i (.mclk(mclk), .rst(rst), .mmr_req(mmr_req), .mmr_rsp(mmr_rsp), .serial_bank(serial_bank),
		.dma_bank(dma_bank), .dma_priority_enable_ctl(dma_priority_enable_ctl));
	// compare and count
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e)
		begin
			$display("FAIL %s expected %h seen %h", n, e, g);
			miscompares++;
		end
	endtask : chk
	// one bus cycle, answer taken one edge later
	task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d, output logic [15:0] q);
		mmr_req = '{w, !w, a, d};
		@(posedge mclk);
		#1 q = mmr_rsp.rdata;
		chk("ack", 16'h0001, {15'h0, mmr_rsp.ack});
	endtask : acc
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		logic [15:0] q;
		acc(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [15:0] e, input string n);
		logic [15:0] q;
		acc(1'b0, a, 16'h0000, q);
		chk(n, e, q);
	endtask : rd
	// expected dma content, zero in the gap
	function automatic logic [15:0] dexp(input int s);
		return (s == 40 || s == 41) ? 16'h0000 : 16'hd000 + 16'(s);
	endfunction : dexp
	// verdict and stop
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	// clock
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// hang guard
	initial
	begin
		cyc = 0;
		forever
		begin
			@(posedge mclk);
			cyc++;
			if (cyc == 5000)
			begin
				miscompares++;
				end_of_test();
			end
		end
	end
	// main sequence
	initial
	begin
		mmr_req = '0;
		rst = 1'b1;
		miscompares = 0;
		samples_checked = 0;
		repeat (20) @(posedge mclk);
		#1 rst = 1'b0;
		rd(16'h0054, 16'h0000, "prio reset");
		for (int p = 0; p < 3; p++)
		begin
			for (int s = 0; s < 28; s++)
			begin
				wr(sdsr_pkg::SER_PTR_ADDR[p], 16'(s));
				wr(sdsr_pkg::SER_DATA_ADDR[p], 16'ha000 + 16'(p * 256 + s));
			end
			// data port writes must not have moved the pointer
			rd(sdsr_pkg::SER_PTR_ADDR[p], 16'h001b, "ser ptr after writes");
			for (int s = 0; s < 28; s++)
			begin
				wr(sdsr_pkg::SER_PTR_ADDR[p], 16'(s));
				rd(sdsr_pkg::SER_DATA_ADDR[p], s == 15 ? 16'h0 : 16'ha000 + 16'(p * 256 + s), "ser");
				chk("ser out", s == 15 ? 16'h0 : 16'ha000 + 16'(p * 256 + s), serial_bank[p][s]);
			end
			rd(sdsr_pkg::SER_PTR_ADDR[p], 16'h001b, "ser ptr");
		end
		// every port keeps its own contents after the others were written
		for (int p = 0; p < 3; p++)
		begin
			for (int s = 0; s < 28; s++)
			begin
				chk("ser keep", s == 15 ? 16'h0 : 16'ha000 + 16'(p * 256 + s), serial_bank[p][s]);
			end
		end
		wr(16'h0055, 16'h0000);
		for (int s = 0; s < 63; s++)
			wr(16'h0056, 16'hd000 + 16'(s));
		rd(16'h0055, 16'h003f, "dma ptr");
		wr(16'h0055, 16'h0000);
		for (int s = 0; s < 63; s++)
		begin
			rd(16'h0056, dexp(s), "dma");
			chk("dma out", dexp(s), dma_bank[s]);
		end
		wr(16'h0055, 16'h0005);
		wr(16'h0057, 16'h1234);
		rd(16'h0057, 16'h1234, "dma plain");
		rd(16'h0055, 16'h0005, "dma ptr held");
		wr(16'h0054, 16'h5a5a);
		rd(16'h0054, 16'h5a5a, "prio");
		chk("prio apart", 16'h1234, dma_bank[5]);
		wr(16'h0036, 16'hffff);
		rd(16'h0036, 16'h0000, "unmapped");
		mmr_req = '0;
		@(posedge mclk);
		end_of_test();
	end
endmodule : sdsr_top_tb
`default_nettype wire
